// >>> logic/core_reset_debug_pkg.sv
// Shared constants and types for the core reset and debug-pause controller
package core_reset_debug_pkg;

  // Address width of the core's instruction side
  localparam int ADDR_W = 32;
  // Reset address read while the core is held in reset
  localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
  // Break address where the debug routine starts
  localparam logic [31:0] BREAK_ADDR = 32'h0000_0020;
  // Cycles between repeated acknowledge pulses while the request holds
  localparam int ACK_PERIOD = 16;
  // Cycles between reads of the reset address while held in reset
  localparam int FETCH_PERIOD = 8;
  // Width of the in-flight instruction counter
  localparam int PIPE_CNT_W = 3;

  // Run states of the core control
  typedef enum logic [1:0] {
    ST_RUN,
    ST_DRAIN,
    ST_HELD,
    ST_PAUSED
  } core_state_e;

endpackage : core_reset_debug_pkg

// >>> logic/period_tick.sv
`timescale 1ns/1ps
// Free counter that pulses once every PERIOD cycles while enabled
module period_tick #(
  parameter int PERIOD = 8
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_run,
  output logic o_tick
);

  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  // Cycle count since the last tick
  logic [CW-1:0] count_reg;

  initial begin
    if (PERIOD < 2) $error("period_tick: PERIOD must be at least 2");
  end

  // Restart from zero whenever not running, so the first tick is a full period away
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      count_reg <= '0;
    end else if (i_ce) begin
      if (!i_run || count_reg == LAST) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + CW'(1);
      end
    end
  end

  // Tick on the last count of the period
  assign o_tick = i_run && (count_reg == LAST);

endmodule : period_tick

// >>> logic/pipe_tracker.sv
`timescale 1ns/1ps
// Counts instructions in flight: issued minus retired
module pipe_tracker #(
  parameter int CNT_W = 3
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_issue,
  input wire logic i_retire,
  output logic o_empty
);

  // Instructions issued and not yet retired
  logic [CNT_W-1:0] inflight_reg;

  initial begin
    if (CNT_W < 1) $error("pipe_tracker: CNT_W must be at least 1");
  end

  // Saturating up/down count; simultaneous issue and retire cancel
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      inflight_reg <= '0;
    end else if (i_ce) begin
      if (i_issue && !i_retire && inflight_reg != '1) begin
        inflight_reg <= inflight_reg + CNT_W'(1);
      end else if (i_retire && !i_issue && inflight_reg != '0) begin
        inflight_reg <= inflight_reg - CNT_W'(1);
      end
    end
  end

  assign o_empty = (inflight_reg == '0);

endmodule : pipe_tracker

// >>> logic/core_reset_debug.sv
`timescale 1ns/1ps
// Reset, local reset request and debug pause control of the processor core
module core_reset_debug
  import core_reset_debug_pkg::*;
#(
  parameter int ACK_GAP = core_reset_debug_pkg::ACK_PERIOD,
  parameter int FETCH_GAP = core_reset_debug_pkg::FETCH_PERIOD,
  parameter int INFLIGHT_W = core_reset_debug_pkg::PIPE_CNT_W
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CE,
  input wire logic I_RESET_REQ,
  input wire logic I_DEBUG_REQ,
  input wire logic I_DEBUG_RELEASE,
  input wire logic I_DEBUG_STEP,
  input wire logic I_ISSUE,
  input wire logic I_RETIRE,
  output logic O_RESET_TAKEN,
  output logic O_DEBUG_ACK,
  output logic O_CORE_HELD,
  output logic O_ISSUE_EN,
  output logic O_REDIRECT,
  output logic [core_reset_debug_pkg::ADDR_W-1:0] O_REDIRECT_ADDR,
  output logic O_FETCH,
  output logic [core_reset_debug_pkg::ADDR_W-1:0] O_FETCH_ADDR,
  output logic O_FETCH_DISCARD
);

  import core_reset_debug_pkg::*;

  initial begin
    if (ACK_GAP < 2) $error("core_reset_debug: ACK_GAP must be at least 2");
    if (FETCH_GAP < 2) $error("core_reset_debug: FETCH_GAP must be at least 2");
  end

  // Control state
  core_state_e state_reg;
  core_state_e state_next;
  // Pipeline drained of issued instructions
  logic pipe_empty;
  // Periodic strobes for acknowledge repeats and reset-address reads
  logic ack_tick;
  logic fetch_tick;
  // One step lets the core run one cycle out of pause
  logic step_reg;
  // Acknowledge, redirect and reset-address read registers
  logic taken_reg;
  logic dbg_ack_reg;
  logic redirect_reg;
  logic [ADDR_W-1:0] redirect_addr_reg;
  logic fetch_reg;
  // Request is visible to the controller only outside pause
  logic req_live;

  // Debug control owns the core while paused, so the request is masked
  assign req_live = I_RESET_REQ && (state_reg != ST_PAUSED);

  // In-flight count lets a local reset wait for completion
  pipe_tracker #(
    .CNT_W(INFLIGHT_W)
  ) u_pipe (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_ce(I_CE),
    .i_issue(I_ISSUE && O_ISSUE_EN),
    .i_retire(I_RETIRE),
    .o_empty(pipe_empty)
  );

  // Acknowledge repeat timer runs only while held with the request up
  period_tick #(
    .PERIOD(ACK_GAP)
  ) u_ack_tick (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_ce(I_CE),
    .i_run(state_reg == ST_HELD && I_RESET_REQ),
    .o_tick(ack_tick)
  );

  // Reset-address read timer runs while held
  period_tick #(
    .PERIOD(FETCH_GAP)
  ) u_fetch_tick (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_ce(I_CE),
    .i_run(state_reg == ST_HELD),
    .o_tick(fetch_tick)
  );

  // Next state; debug pause takes priority over a new local reset request in the run state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (I_DEBUG_REQ) begin
          state_next = ST_PAUSED;
        end else if (req_live) begin
          state_next = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        // Issue is stopped; wait for the pipeline to empty
        if (pipe_empty) begin
          state_next = ST_HELD;
        end
      end
      ST_HELD: begin
        // Leave only when the request drops
        if (!I_RESET_REQ) begin
          state_next = ST_RUN;
        end
      end
      ST_PAUSED: begin
        // Debug request here is ignored; only release or step leaves
        if (I_DEBUG_RELEASE || I_DEBUG_STEP) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  // State register; synchronous reset acts at the very next edge
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      state_reg <= ST_RUN;
    end else if (I_CE) begin
      if (step_reg && state_reg == ST_RUN && !I_RESET_REQ) begin
        // Single step finished with no reset pending: pause again
        state_reg <= ST_PAUSED;
      end else begin
        state_reg <= state_next;
      end
    end
  end

  // Remember that the current run slot is a single step
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      step_reg <= 1'b0;
    end else if (I_CE) begin
      step_reg <= (state_reg == ST_PAUSED) && I_DEBUG_STEP && !I_DEBUG_RELEASE;
    end
  end

  // Acknowledge pulse: entry into held state, then each period while request holds
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      taken_reg <= 1'b0;
    end else if (I_CE) begin
      taken_reg <= (state_reg == ST_DRAIN && pipe_empty) || ack_tick;
    end
  end
  // Pulse lasts one clock even if the clock enable stalls afterwards
  assign O_RESET_TAKEN = taken_reg && I_CE;

  // Debug acknowledge stands for the whole pause
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      dbg_ack_reg <= 1'b0;
    end else if (I_CE) begin
      // Follows the state register exactly, including the re-pause after a step
      dbg_ack_reg <= (state_next == ST_PAUSED) || (step_reg && state_reg == ST_RUN && !I_RESET_REQ);
    end
  end
  assign O_DEBUG_ACK = dbg_ack_reg;

  // Redirect to the break routine on a debug request while running, to reset address on leaving reset
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      redirect_reg <= 1'b0;
      redirect_addr_reg <= '0;
    end else if (I_CE) begin
      redirect_reg <= 1'b0;
      if (state_reg == ST_RUN && I_DEBUG_REQ) begin
        redirect_reg <= 1'b1;
        redirect_addr_reg <= BREAK_ADDR;
      end else if (state_reg == ST_HELD && !I_RESET_REQ) begin
        redirect_reg <= 1'b1;
        redirect_addr_reg <= RESET_ADDR;
      end
    end
  end
  assign O_REDIRECT = redirect_reg;
  assign O_REDIRECT_ADDR = redirect_addr_reg;

  // Dummy reads of the reset address while held; the data is thrown away
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      fetch_reg <= 1'b0;
    end else if (I_CE) begin
      // No read is started on the edge that leaves the held state
      fetch_reg <= fetch_tick && I_RESET_REQ;
    end
  end
  assign O_FETCH = fetch_reg && I_CE;
  assign O_FETCH_ADDR = RESET_ADDR;
  assign O_FETCH_DISCARD = (state_reg == ST_HELD);

  // Only the core's own state is touched; no reset leaves this block
  assign O_CORE_HELD = (state_reg == ST_HELD) || !I_RESET_N;
  // Issue stops for drain, hold and pause
  assign O_ISSUE_EN = I_RESET_N && (state_reg == ST_RUN);

  // The requester keeps the request up until acknowledged; a drop before then
  // still holds the core for one cycle, with an acknowledge pulse, after the drain, then it runs

endmodule : core_reset_debug

// >>> testbench/core_reset_debug_asserts.sv
// Port checker for the core reset and debug-pause controller
`timescale 1ns/1ps
module core_reset_debug_asserts
  import core_reset_debug_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CE,
  input wire logic I_RESET_REQ,
  input wire logic I_DEBUG_REQ,
  input wire logic O_RESET_TAKEN,
  input wire logic O_DEBUG_ACK,
  input wire logic O_CORE_HELD,
  input wire logic O_ISSUE_EN,
  input wire logic O_REDIRECT,
  input wire logic [core_reset_debug_pkg::ADDR_W-1:0] O_REDIRECT_ADDR,
  input wire logic O_FETCH,
  input wire logic [core_reset_debug_pkg::ADDR_W-1:0] O_FETCH_ADDR,
  input wire logic O_FETCH_DISCARD
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  // Global reset needs no edge to stop the core
  a_global_reset_holds: assert property (disable iff (1'b0) !I_RESET_N |-> O_CORE_HELD && !O_ISSUE_EN)
    else $error("core not held in global reset");
  a_taken_single: assert property (O_RESET_TAKEN |=> !O_RESET_TAKEN)
    else $error("acknowledge longer than one cycle");
  // No acknowledge while running or draining
  a_taken_only_held: assert property (O_RESET_TAKEN |-> O_CORE_HELD)
    else $error("acknowledge outside reset state");
  a_held_no_issue: assert property (O_CORE_HELD |-> !O_ISSUE_EN)
    else $error("issue enabled while held");
  a_fetch_reset_addr: assert property (O_FETCH |-> O_CORE_HELD && O_FETCH_ADDR == RESET_ADDR)
    else $error("fetch outside reset or wrong address");
  a_held_while_req: assert property (O_CORE_HELD && I_RESET_REQ && I_CE |=> O_CORE_HELD)
    else $error("core left reset with request high");
  a_release_redirect: assert property (O_CORE_HELD && !I_RESET_REQ && I_CE
    |=> !O_CORE_HELD && O_REDIRECT && O_REDIRECT_ADDR == RESET_ADDR)
    else $error("no restart at reset address");
  a_debug_answer: assert property (I_DEBUG_REQ && O_ISSUE_EN && !O_DEBUG_ACK && I_CE
    |=> O_DEBUG_ACK && O_REDIRECT && O_REDIRECT_ADDR == BREAK_ADDR)
    else $error("pause not taken to break address");
  // A paused core must not start a local reset
  a_paused_not_held: assert property (O_DEBUG_ACK |-> !O_CORE_HELD && !O_ISSUE_EN)
    else $error("paused core held or issuing");
  a_repeat_pause_quiet: assert property (O_DEBUG_ACK && I_DEBUG_REQ |=> !O_REDIRECT)
    else $error("pause request while paused redirected");

  a_fetch_discarded: assert property (O_FETCH |-> O_FETCH_DISCARD)
    else $error("reset-address read data not discarded");

  c_taken: cover property (O_RESET_TAKEN);
  c_fetch: cover property (O_FETCH);
  c_paused_req: cover property (O_DEBUG_ACK && I_RESET_REQ);
endmodule : core_reset_debug_asserts

bind core_reset_debug core_reset_debug_asserts i_core_reset_debug_asserts (.*);

// >>> testbench/reset_requester.sv
// System-side model that raises the local reset request
`timescale 1ns/1ps
module reset_requester (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic i_taken,
  input wire logic signed [31:0] i_hold,
  output logic o_req
);
  int left = -1; // Cycles still held after the acknowledge

  initial o_req = 1'b0;

  // Never lets go before an acknowledge, so a slow drain is not cut short
  always @(posedge i_clk) begin
    if (i_start) begin
      o_req <= 1'b1;
      left <= -1;
    end else if (o_req && left < 0) begin
      if (i_taken) left <= i_hold;
    end else if (left > 0) begin
      left <= left - 1;
    end else begin
      o_req <= 1'b0;
    end
  end
endmodule : reset_requester

// >>> testbench/core_reset_debug_tb.sv
// Self-checking bench of the core reset and debug-pause controller
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %0d got %0d", n, e, s); end end
module core_reset_debug_tb;
  import core_reset_debug_pkg::*;
  logic clk = 0, rst_n = 0, dbg = 0, rel = 0, stp = 0, iss = 0, ret = 0, start = 0; // Inputs
  logic req, taken, ack, held, ien, fetch; // Observed pins
  int errors, samples_checked, seed = 70371, cyc, inflight, nx, n_take, n_fetch, hold, i;
  bit busy; // Enables random issue

  always #12.5 clk = ~clk;

  // Short periods so the pulses repeat often
  core_reset_debug #(.ACK_GAP(4), .FETCH_GAP(2)) i_core_reset_debug (.I_CLK(clk), .I_RESET_N(rst_n),
    .I_CE(1'b1), .I_RESET_REQ(req), .I_DEBUG_REQ(dbg), .I_DEBUG_RELEASE(rel), .I_DEBUG_STEP(stp),
    .I_ISSUE(iss), .I_RETIRE(ret), .O_RESET_TAKEN(taken), .O_DEBUG_ACK(ack), .O_CORE_HELD(held),
    .O_ISSUE_EN(ien), .O_REDIRECT(), .O_REDIRECT_ADDR(), .O_FETCH(fetch), .O_FETCH_ADDR(),
    .O_FETCH_DISCARD());
  reset_requester i_reset_requester (.i_clk(clk), .i_start(start), .i_taken(taken), .i_hold(hold), .o_req(req));

  // Pulses seen when the requester holds h cycles past the first one
  function automatic int exp_pulses(int h);
    return 1 + (h + 1) / 4;
  endfunction : exp_pulses

  task automatic print_verdict();
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // Waits for the requester to let go, then for the core to restart
  task automatic wait_drop();
    do @(posedge clk); while (req);
    repeat (3) @(posedge clk);
  endtask : wait_drop

  // Random traffic; only issues the core accepts are counted
  always @(posedge clk) begin
    nx = rst_n ? inflight + (iss && ien) - ret : 0;
    if (taken) `CHK("drained", 0, inflight)
    n_take += taken;
    n_fetch += fetch;
    inflight <= nx;
    iss <= busy && nx < 6 && $random(seed) % 2 != 0;
    ret <= nx > 0 && $random(seed) % 2 != 0;
    cyc++;
    if (cyc > 5000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    busy = 1;
    // Local resets, hold times chosen off the pulse boundaries
    for (i = 0; i < 8; i++) begin
      hold = 4 * ($unsigned($random(seed)) % 3) + 3 * ($random(seed) & 1);
      repeat (5) @(posedge clk);
      n_take = 0;
      n_fetch = 0;
      start <= 1;
      @(posedge clk);
      start <= 0;
      wait_drop();
      `CHK("pulses", exp_pulses(hold), n_take)
      `CHK("fetched", 1'b1, hold < 4 || n_fetch > 0)
    end
    // Pause, ignored requests, then leave by step and by resume
    for (i = 0; i < 2; i++) begin
      n_take = 0;
      hold = 0;
      dbg <= 1;
      @(posedge clk);
      start <= 1;
      @(posedge clk);
      start <= 0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      `CHK("paused", 1'b1, ack)
      `CHK("held", 1'b0, held)
      `CHK("ignored", 0, n_take)
      @(posedge clk);
      dbg <= 0;
      stp <= i == 0;
      rel <= i == 1;
      @(posedge clk);
      stp <= 0;
      rel <= 0;
      wait_drop();
      `CHK("resumed", 1, n_take)
    end
    // Global reset in mid-traffic
    rst_n <= 0;
    @(negedge clk);
    `CHK("reset held", 1'b1, held)
    @(posedge clk);
    rst_n <= 1;
    @(negedge clk);
    `CHK("running", 1'b1, ien)
    print_verdict();
  end
endmodule : core_reset_debug_tb
